// File: hw/tpw_pkg.sv
// constants and field layout for the three-phase pwm timing block
package tpw_pkg;
	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam logic [2:0] ADDR_HOLD_LO = 3'h0;
	localparam logic [2:0] ADDR_HOLD_MID = 3'h1;
	localparam logic [2:0] ADDR_HOLD_HI = 3'h2;
	localparam logic [2:0] ADDR_CTRL_XFER = 3'h3;
	localparam logic [2:0] ADDR_SETUP_XFER = 3'h4;
	// ----------------------------------------
	// set-up register fields
	// ----------------------------------------
	localparam int SU_MINW_LSB = 0;
	localparam int SU_CDIV_LSB = 8;
	localparam int SU_RANGE_LSB = 11;
	localparam int SU_HOLD_BIT = 14;
	localparam int SU_DEAD_LSB = 16;
	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int CT_SPEED_LSB = 0;
	localparam int CT_INH_BIT = 13;
	localparam int CT_OM_BIT = 14;
	localparam int CT_DIR_BIT = 15;
	localparam int CT_AMP_LSB = 16;
	// ----------------------------------------
	// carrier, phase and waveform constants
	// ----------------------------------------
	localparam logic [7:0] CAR_MAX = 8'hff;
	localparam logic [29:0] PHASE_MOD = 30'h30000000;
	localparam int PHASE_LSB = 20;
	localparam logic [9:0] ANGLE_FULL = 10'h300;
	localparam logic [9:0] ANGLE_HALF = 10'h180;
	localparam logic [9:0] ANGLE_THIRD = 10'h100;
	localparam int WAVE_MID = 192;
	localparam int WAVE_GAIN = 21;
	localparam int WAVE_SHIFT = 13;
	localparam int REF_TOP = 256;
	localparam logic [8:0] REF_MID = 9'h080;
	localparam logic [2:0] RANGE_MAX = 3'h6;
	localparam logic [2:0] CDIV_MAX = 3'h5;
	localparam logic [6:0] DEAD_SAT = 7'h40;
endpackage : tpw_pkg

// File: hw/tpw_core.sv
// three-phase pwm generator with set-up, filter and dead-time logic
`timescale 1ns/1ns
`default_nettype none
module tpw_core (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_wr_en,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_trip,
	output logic [2:0] o_pwm_top,
	output logic [2:0] o_pwm_bot
);
	import tpw_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] holding_byte_low;
		logic [7:0] holding_byte_mid;
		logic [7:0] holding_byte_high;
		logic [23:0] setup_parameter_register;
		logic [23:0] run_control_register;
		logic [4:0] div_cnt;
		logic [7:0] car;
		logic car_dn;
		logic [29:0] acc;
		logic [2:0][8:0] ref_lvl;
		logic [2:0][7:0] pd_cnt;
		logic [2:0] filt;
		logic [2:0][6:0] dt_cnt;
		logic [2:0] top;
		logic [2:0] bot;
	} tpw_state_t;

	tpw_state_t q;
	tpw_state_t d;

	// ----------------------------------------
	// decode functions
	// ----------------------------------------
	function automatic logic [5:0] cdiv_ratio(input logic [2:0] code);
		logic [2:0] c;
		c = (code > CDIV_MAX) ? CDIV_MAX : code;
		cdiv_ratio = 6'(1) << c;
	endfunction : cdiv_ratio

	function automatic logic [17:0] speed_inc(input logic [2:0] code,
		input logic [11:0] speed);
		logic [2:0] c;
		c = (code > RANGE_MAX) ? RANGE_MAX : code;
		speed_inc = {6'h00, speed} << c;
	endfunction : speed_inc

	function automatic logic [9:0] angle_add(input logic [9:0] a,
		input logic [9:0] off);
		logic [10:0] s;
		s = {1'b0, a} + {1'b0, off};
		angle_add = (s >= {1'b0, ANGLE_FULL}) ?
			10'(s - {1'b0, ANGLE_FULL}) : s[9:0];
	endfunction : angle_add

	// triangle reference scaled by amplitude, clamped to carrier span
	function automatic logic [8:0] wave_ref(input logic [9:0] a,
		input logic [8:0] amp);
		int v;
		int m;
		v = (a < ANGLE_HALF) ? int'(a) : int'(ANGLE_FULL) - 1 - int'(a);
		m = ((v - WAVE_MID) * int'(amp) * WAVE_GAIN) >>> WAVE_SHIFT;
		m = m + int'(REF_MID);
		if (m < 0) begin
			m = 0;
		end
		if (m > REF_TOP) begin
			m = REF_TOP;
		end
		wave_ref = 9'(m);
	endfunction : wave_ref

	// ----------------------------------------
	// field views
	// ----------------------------------------
	logic [2:0] carrier_divider_field;
	logic [2:0] speed_range_field;
	logic phase_counter_hold;
	logic [6:0] dead_count;
	logic [7:0] minw_count;
	logic [11:0] speed_word;
	logic [8:0] amp_word;
	logic out_enable;
	logic dir_rev;
	logic step;
	logic [2:0] raw;
	logic [9:0] angle;
	logic [2:0][9:0] ph_angle;

	assign carrier_divider_field = q.setup_parameter_register[SU_CDIV_LSB +: 3];
	assign speed_range_field = q.setup_parameter_register[SU_RANGE_LSB +: 3];
	assign phase_counter_hold = q.setup_parameter_register[SU_HOLD_BIT];
	assign dead_count =
		{1'b0, ~q.setup_parameter_register[SU_DEAD_LSB +: 6]} + 7'h01;
	assign minw_count =
		{1'b0, ~q.setup_parameter_register[SU_MINW_LSB +: 7]} + 8'h01;
	assign speed_word = q.run_control_register[CT_SPEED_LSB +: 12];
	assign amp_word = {q.run_control_register[CT_OM_BIT],
		q.run_control_register[CT_AMP_LSB +: 8]};
	assign dir_rev = q.run_control_register[CT_DIR_BIT];
	assign out_enable = q.run_control_register[CT_INH_BIT] & ~i_trip;
	assign step = (q.div_cnt ==
		5'(cdiv_ratio(carrier_divider_field) - 6'h01));
	assign angle = q.acc[PHASE_LSB +: 10];
	assign ph_angle[0] = angle;
	assign ph_angle[1] = angle_add(angle, ANGLE_FULL - ANGLE_THIRD);
	assign ph_angle[2] = angle_add(angle, ANGLE_THIRD);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [29:0] inc;
		logic [30:0] sum;
		logic turn;
		inc = {12'h000, speed_inc(speed_range_field, speed_word)};
		sum = 31'h0;
		turn = 1'b0;
		d = q;
		if (i_wr_en) begin
			case (i_addr)
				ADDR_HOLD_LO: d.holding_byte_low = i_wdata;
				ADDR_HOLD_MID: d.holding_byte_mid = i_wdata;
				ADDR_HOLD_HI: d.holding_byte_high = i_wdata;
				ADDR_CTRL_XFER: d.run_control_register = {q.holding_byte_high,
					q.holding_byte_mid, q.holding_byte_low};
				ADDR_SETUP_XFER: d.setup_parameter_register = {q.holding_byte_high,
					q.holding_byte_mid, q.holding_byte_low};
				default: d.holding_byte_low = q.holding_byte_low;
			endcase
		end
		d.div_cnt = step ? 5'h00 : 5'(q.div_cnt + 5'h01);
		if (step) begin
			if (!q.car_dn) begin
				if (q.car == CAR_MAX) begin
					d.car_dn = 1'b1;
					turn = 1'b1;
				end else begin
					d.car = 8'(q.car + 8'h01);
				end
			end else begin
				if (q.car == 8'h00) begin
					d.car_dn = 1'b0;
					turn = 1'b1;
				end else begin
					d.car = 8'(q.car - 8'h01);
				end
			end
			if (dir_rev) begin
				sum = {1'b0, q.acc} - {1'b0, inc};
				if (sum[30]) begin
					sum = 31'(sum + {1'b0, PHASE_MOD});
				end
			end else begin
				sum = {1'b0, q.acc} + {1'b0, inc};
				if (sum >= {1'b0, PHASE_MOD}) begin
					sum = 31'(sum - {1'b0, PHASE_MOD});
				end
			end
			d.acc = sum[29:0];
		end
		if (!phase_counter_hold) begin
			d.acc = 30'h0;
		end
		for (int i = 0; i < 3; i++) begin
			if (turn) begin
				d.ref_lvl[i] = phase_counter_hold ?
					wave_ref(ph_angle[i], amp_word) : REF_MID;
			end
			raw[i] = {1'b0, q.car} < q.ref_lvl[i];
			if (raw[i] == q.filt[i]) begin
				d.pd_cnt[i] = 8'h00;
			end else if (step) begin
				if (8'(q.pd_cnt[i] + 8'h01) >= minw_count) begin
					d.filt[i] = raw[i];
					d.pd_cnt[i] = 8'h00;
				end else begin
					d.pd_cnt[i] = 8'(q.pd_cnt[i] + 8'h01);
				end
			end
			if (d.filt[i] != q.filt[i]) begin
				d.dt_cnt[i] = 7'h00;
			end else if (step && q.dt_cnt[i] < DEAD_SAT) begin
				d.dt_cnt[i] = 7'(q.dt_cnt[i] + 7'h01);
			end
			d.top[i] = q.filt[i] && q.dt_cnt[i] >= dead_count
				&& out_enable;
			d.bot[i] = !q.filt[i] && q.dt_cnt[i] >= dead_count
				&& out_enable;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_pwm_top = q.top;
	assign o_pwm_bot = q.bot;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_setup_load;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_wr_en && i_addr == ADDR_SETUP_XFER) |=> q.setup_parameter_register ==
			$past({q.holding_byte_high, q.holding_byte_mid, q.holding_byte_low});
	endproperty
	a_setup_load: assert property (p_setup_load) else $error("setup load");

	property p_ctrl_load;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_wr_en && i_addr == ADDR_CTRL_XFER) |=> q.run_control_register ==
			$past({q.holding_byte_high, q.holding_byte_mid, q.holding_byte_low});
	endproperty
	a_ctrl_load: assert property (p_ctrl_load) else $error("control load");

	property p_hold_only;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_wr_en && i_addr < ADDR_CTRL_XFER) |=>
			$stable(q.setup_parameter_register) && $stable(q.run_control_register);
	endproperty
	a_hold_only: assert property (p_hold_only) else $error("early load");

	property p_reset_low;
		@(posedge i_clk) $rose(i_reset_n) |-> (o_pwm_top | o_pwm_bot) == 3'h0;
	endproperty
	a_reset_low: assert property (p_reset_low) else $error("out in reset");

	property p_no_overlap;
		@(posedge i_clk) disable iff (!i_reset_n)
		(o_pwm_top & o_pwm_bot) == 3'h0;
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("overlap");

	property p_inhibit;
		@(posedge i_clk) disable iff (!i_reset_n)
		!out_enable |=> (o_pwm_top | o_pwm_bot) == 3'h0;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("inhibit");

	property p_phase_hold;
		@(posedge i_clk) disable iff (!i_reset_n)
		!phase_counter_hold ##1 !phase_counter_hold |-> q.acc == 30'h0;
	endproperty
	a_phase_hold: assert property (p_phase_hold) else $error("hold");

	property p_rise_delay;
		@(posedge i_clk) disable iff (!i_reset_n)
		$rose(o_pwm_top[0]) |-> $past(q.dt_cnt[0]) >= $past(dead_count);
	endproperty
	a_rise_delay: assert property (p_rise_delay) else $error("dead");

	property p_divider;
		@(posedge i_clk) disable iff (!i_reset_n)
		step |=> q.div_cnt == 5'h00;
	endproperty
	a_divider: assert property (p_divider) else $error("divider");

	property p_trip;
		@(posedge i_clk) disable iff (!i_reset_n)
		i_trip |=> (o_pwm_top | o_pwm_bot) == 3'h0;
	endproperty
	a_trip: assert property (p_trip) else $error("trip");

	property p_fall_fast;
		@(posedge i_clk) disable iff (!i_reset_n)
		$fell(q.filt[0]) |=> !o_pwm_top[0];
	endproperty
	a_fall_fast: assert property (p_fall_fast) else $error("late fall");

	property p_dead_code;
		@(posedge i_clk) disable iff (!i_reset_n)
		dead_count != 7'h00 && dead_count <= DEAD_SAT;
	endproperty
	a_dead_code: assert property (p_dead_code) else $error("dead code");

	property p_minw_code;
		@(posedge i_clk) disable iff (!i_reset_n)
		minw_count != 8'h00 && minw_count <= 8'h80;
	endproperty
	a_minw_code: assert property (p_minw_code) else $error("width code");

	property p_car_turn;
		@(posedge i_clk) disable iff (!i_reset_n)
		(step && q.car_dn && q.car == 8'h00) |=> !q.car_dn;
	endproperty
	a_car_turn: assert property (p_car_turn) else $error("carrier");

	property p_top_filt;
		@(posedge i_clk) disable iff (!i_reset_n)
		o_pwm_top[0] |-> $past(q.filt[0]);
	endproperty
	a_top_filt: assert property (p_top_filt) else $error("filter");
endmodule : tpw_core
`default_nettype wire

// File: test/tpw_bridge_model.sv
// gate drive stage model measuring red phase timing
`timescale 1ns/1ns
`default_nettype none
module tpw_bridge_model (
	input wire logic i_clk,
	input wire logic [2:0] i_top,
	input wire logic [2:0] i_bot,
	output var logic [31:0] o_period,
	output var logic [31:0] o_gap,
	output var logic [31:0] o_rises,
	output var logic [31:0] o_shoots
);
	logic [31:0] cyc_q = 32'h0;
	logic [31:0] last_q = 32'h0;
	logic [31:0] low_q = 32'h0;
	logic prev_q = 1'b0;
	logic [31:0] period_q = 32'h0;
	logic [31:0] gap_q = 32'h0;
	logic [31:0] rises_q = 32'h0;
	logic [31:0] shoots_q = 32'h0;
	assign o_period = period_q;
	assign o_gap = gap_q;
	assign o_rises = rises_q;
	assign o_shoots = shoots_q;
	always @(posedge i_clk) begin
		cyc_q <= cyc_q + 32'h1;
		prev_q <= i_top[0];
		low_q <= (i_top[0] | i_bot[0]) ? 32'h0 : low_q + 32'h1;
		if (|(i_top & i_bot)) begin
			shoots_q <= shoots_q + 32'h1;
		end
		if (i_top[0] && !prev_q) begin
			period_q <= cyc_q - last_q;
			last_q <= cyc_q;
			gap_q <= low_q;
			rises_q <= rises_q + 32'h1;
		end
	end
endmodule : tpw_bridge_model
`default_nettype wire

// File: test/tb_three_phase_pwm_timing_setup.sv
// self-checking bench for the three-phase pwm timing block
`timescale 1ns/1ns
`default_nettype none
module tb_three_phase_pwm_timing_setup;
	import tpw_pkg::*;
	typedef struct packed {
		logic [2:0] cdiv;
		logic [5:0] dead;
		logic [6:0] minw;
		logic [31:0] per;
		logic [31:0] gap;
	} tpw_row_t;
	logic i_clk, i_reset_n, i_wr_en, i_trip;
	logic [2:0] i_addr, o_pwm_top, o_pwm_bot;
	logic [7:0] i_wdata;
	logic [31:0] period, gap, rises, shoots, r0;
	int num_errors = 0;
	int comparisons = 0;
	tpw_row_t rows [6] = '{
		'{3'h0, 6'h3f, 7'h7f, 32'h200, 32'h1},
		'{3'h1, 6'h3c, 7'h7f, 32'h400, 32'h8},
		'{3'h2, 6'h30, 7'h7f, 32'h800, 32'h40},
		'{3'h3, 6'h3e, 7'h7f, 32'h1000, 32'h10},
		'{3'h4, 6'h3f, 7'h7f, 32'h2000, 32'h10},
		'{3'h5, 6'h00, 7'h00, 32'h4000, 32'h800}};
	tpw_core i_tpw_core (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_wr_en(i_wr_en), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_trip(i_trip), .o_pwm_top(o_pwm_top), .o_pwm_bot(o_pwm_bot));
	tpw_bridge_model i_tpw_bridge_model (.i_clk(i_clk), .i_top(o_pwm_top),
		.i_bot(o_pwm_bot), .o_period(period), .o_gap(gap),
		.o_rises(rises), .o_shoots(shoots));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic conclude();
		if (num_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_wr_en = 1'b1;
		i_addr = a;
		i_wdata = d;
		@(negedge i_clk);
		i_wr_en = 1'b0;
	endtask : wr
	task automatic load(input logic [2:0] xa, input logic [23:0] w);
		wr(ADDR_HOLD_LO, w[7:0]);
		wr(ADDR_HOLD_MID, w[15:8]);
		wr(ADDR_HOLD_HI, w[23:16]);
		wr(xa, 8'ha5);
	endtask : load
	function automatic logic [23:0] su(input tpw_row_t r);
		return (24'(r.cdiv) << SU_CDIV_LSB) | (24'(r.dead) << SU_DEAD_LSB)
			| (24'(r.minw) << SU_MINW_LSB);
	endfunction : su
	task automatic wait_rise();
		logic [31:0] s;
		s = rises;
		for (int k = 0; k < 20000 && rises === s; k++) @(negedge i_clk);
		if (rises === s) begin
			chk(rises, s + 32'h1);
		end
	endtask : wait_rise
	task automatic quiet();
		repeat (2) @(negedge i_clk);
		r0 = rises;
		repeat (1100) @(negedge i_clk);
		chk(rises, r0);
		chk(32'({o_pwm_top, o_pwm_bot}), 32'h0);
	endtask : quiet
	task automatic pulse_reset();
		@(negedge i_clk);
		i_reset_n = 1'b0;
		@(negedge i_clk);
		chk(32'({o_pwm_top, o_pwm_bot}), 32'h0);
		i_reset_n = 1'b1;
	endtask : pulse_reset
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	initial begin
		#1800000;
		num_errors++;
		conclude();
	end
	initial begin
		i_reset_n = 1'b0;
		i_wr_en = 1'b0;
		i_trip = 1'b0;
		i_addr = 3'h0;
		i_wdata = 8'h0;
		repeat (12) begin
			@(negedge i_clk);
			chk(32'({o_pwm_top, o_pwm_bot}), 32'h0);
		end
		i_reset_n = 1'b1;
		load(ADDR_SETUP_XFER, su(rows[0]));
		quiet();
		load(ADDR_CTRL_XFER, 24'h1 << CT_INH_BIT);
		// holding byte and unmapped writes must not retime the carrier
		wr(ADDR_HOLD_MID, 8'h03);
		for (int a = 5; a < 8; a++) wr(3'(a), 8'hff);
		wait_rise();
		wait_rise();
		wait_rise();
		chk(period, 32'h200);
		load(ADDR_CTRL_XFER, 24'h0);
		quiet();
		load(ADDR_CTRL_XFER, 24'h1 << CT_INH_BIT);
		wait_rise();
		wait_rise();
		wait_rise();
		chk(period, 32'h200);
		i_trip = 1'b1;
		quiet();
		i_trip = 1'b0;
		// each row starts from reset so the second rise gives a clean period
		for (int i = 0; i < 6; i++) begin
			pulse_reset();
			load(ADDR_SETUP_XFER, su(rows[i]));
			load(ADDR_CTRL_XFER, 24'h1 << CT_INH_BIT);
			wait_rise();
			wait_rise();
			chk(period, rows[i].per);
			chk(gap, rows[i].gap);
		end
		// running phase counter, reversed, half amplitude, top range
		pulse_reset();
		load(ADDR_SETUP_XFER, su(rows[0]) | (24'h1 << SU_HOLD_BIT)
			| (24'h6 << SU_RANGE_LSB));
		load(ADDR_CTRL_XFER, (24'h1 << CT_INH_BIT) | (24'h1 << CT_DIR_BIT)
			| (24'h80 << CT_AMP_LSB) | 24'hfff);
		r0 = rises;
		wait_rise();
		wait_rise();
		chk(rises, r0 + 32'h2);
		chk(shoots, 32'h0);
		@(negedge i_clk);
		i_reset_n = 1'b0;
		@(negedge i_clk);
		chk(32'({o_pwm_top, o_pwm_bot}), 32'h0);
		conclude();
	end
endmodule : tb_three_phase_pwm_timing_setup
`default_nettype wire
